// [design/ccs_pkg.sv]
// Package for the processor control and status register block.
// Assumes one 20 MHz clock and a core that presents single-cycle command pulses.
package ccs_pkg;

    // Clock and timer tick rates, in Hz
    localparam int unsigned CLK_HZ       = 20_000_000;
    localparam int unsigned FAST_TICK_HZ = 100_000;
    localparam int unsigned SLOW_TICK_HZ = 10_000;
    // Clock cycles per timer tick, derived from the rates
    localparam int unsigned FAST_DIV     = CLK_HZ / FAST_TICK_HZ;
    localparam int unsigned SLOW_DIV     = CLK_HZ / SLOW_TICK_HZ;

    // I/O address of the configuration word read
    localparam logic [15:0] CFG_IO_ADDR  = 16'h8410;

    // Fault bit positions (vector index equals documented bit number)
    localparam int FT_CPU_PROT   = 0;
    localparam int FT_EXT_PROT   = 1;
    localparam int FT_PARITY     = 2;
    localparam int FT_ILL_IO     = 5;
    localparam int FT_SYS0       = 7;
    localparam int FT_ILL_MEM    = 8;
    localparam int FT_ILL_INSTR  = 9;
    localparam int FT_PRIV       = 10;
    localparam int FT_ADDR_STATE = 11;
    localparam int FT_BUILTIN_TEST_FAULT       = 13;
    localparam int FT_SYS1       = 15;
    // Severity classes of fault bits
    localparam logic [15:0] FT_MAJOR_MASK   = 16'h0521;
    localparam logic [15:0] FT_UNREC_MASK   = 16'h0B85;
    localparam logic [15:0] FT_UNCLASS_MASK = 16'hA006;

    // Status word fields
    localparam int SW_FLAG_LSB = 0;
    localparam int SW_PS_LSB   = 8;
    localparam int SW_AS_LSB   = 12;
    localparam logic [15:0] SW_WRITE_MASK = 16'hFF0F;

    // Configuration word bits
    localparam int CFG_MMU     = 0;
    localparam int CFG_BPU     = 1;
    localparam int CFG_CONSOLE = 2;
    localparam int CFG_COPROC  = 3;
    localparam int CFG_LEVEL   = 4;
    localparam logic [15:0] CFG_USED_MASK = 16'h001F;

    // Interrupt positions and sources
    localparam int PI_MACH_ERR  = 1;
    localparam int PI_FP_OVF    = 3;
    localparam int PI_FX_OVF    = 4;
    localparam int PI_EXEC_CALL = 5;
    localparam int PI_FP_UNF    = 6;
    localparam int PI_FAST_TMR  = 7;
    localparam int PI_SLOW_TMR  = 9;
    localparam logic [15:0] PI_EXT_MASK    = 16'hFD05;
    localparam logic [15:0] PI_LVL_ONLY    = 16'h5000;
    localparam logic [15:0] PI_NO_MASK     = 16'h0021;
    localparam logic [15:0] PI_NO_DISABLE  = 16'h0023;

    // Reset values
    localparam logic [15:0] RST_WORD = 16'h0000;

    // Fault events reported by the core, one-cycle pulses
    typedef struct packed {
        logic cpu_prot;
        logic ext_prot;
        logic parity;
        logic ill_io;
        logic sys0;
        logic ill_mem;
        logic ill_instr;
        logic builtin_test_fault;
        logic sys1;
    } ccs_fault_type;

    // Internal interrupt events from the execution core
    typedef struct packed {
        logic fp_ovf;
        logic fx_ovf;
        logic exec_call;
        logic fp_unf;
    } ccs_event_type;

    // Timer I/O commands, index 0 fast timer, index 1 slow timer
    typedef struct packed {
        logic [1:0]  load_start;
        logic [1:0]  halt;
        logic [1:0]  read;
        logic [15:0] wdata;
    } ccs_tmr_cmd_type;

    // Configuration load sequencer states
    typedef enum logic [1:0] {
        CFG_IDLE = 2'b01,
        CFG_WAIT = 2'b10
    } ccs_cfg_state_type;

endpackage

// [design/ccs_regs.sv]
// Dedicated control and status registers of the processor core.
// Assumes core commands are single-cycle pulses and external I/O answers the config read.
// Contract
// - Fault bits 0,1,2,5 for protect, parity, IO
// - Fault bits 7,8,9,13,15; spares read zero
// - Classify faults; raise machine error interrupt
// - Arithmetic updates carry, positive, zero, negative flags
// - Status bits 4 to 7 read zero
// - Access key bits 8-11, address state 12-15
// - Privileged needs state zero, else fault 10
// - No MMU: nonzero address state sets fault 11
// - Interrupt status load aborts on nonzero state without MMU
// - Read config at 8410 on reset, breakpoint
// - Config bits: MMU, block protect, console present
// - Config bit 3 coprocessor; else builtin illegal
// - Config bit 4 selects level or edge
// - Two 16-bit timers at 100 and 10 kHz
// - Timer rollover sets pending bits 7 and 9
// - Load command loads timer and starts counting
// - Timers freeze in console mode
// - Latch requests; bit 0 highest priority
// - Mask zero ignores; save mask and counter
// - External and internal sources; IO levels level-only
// - Power down, exec call unmaskable; machine error
module ccs_regs
    import ccs_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            resetn,
    input  wire ccs_fault_type   fault_evt,
    input  wire ccs_event_type   core_evt,
    input  wire logic            fault_clr,
    input  wire logic            flags_we,
    input  wire logic [3:0]      flags_in,
    input  wire logic            sw_we,
    input  wire logic [15:0]     sw_wdata,
    input  wire logic            int_sw_load,
    input  wire logic [15:0]     int_sw_data,
    input  wire logic            priv_exec,
    input  wire logic            bif_exec,
    input  wire logic            breakpoint,
    input  wire logic            console_mode,
    input  wire logic            glob_disable,
    input  wire logic [15:0]     ext_irq,
    input  wire logic            mask_we,
    input  wire logic [15:0]     mask_wdata,
    input  wire logic            int_ack,
    input  wire logic [3:0]      int_ack_level,
    input  wire logic [15:0]     instruction_counter,
    input  wire ccs_tmr_cmd_type tmr_cmd,
    input  wire logic            cfg_rd_valid,
    input  wire logic [15:0]     cfg_rd_data,
    output logic [15:0]          fault_cause,
    output logic                 fault_major,
    output logic                 fault_unrec,
    output logic                 fault_unclass,
    output logic [15:0]          status_word,
    output logic [15:0]          system_configuration,
    output logic [15:0]          interrupt_pending,
    output logic [15:0]          interrupt_mask,
    output logic                 int_req,
    output logic [3:0]           int_level,
    output logic [15:0]          saved_mask,
    output logic [15:0]          saved_ic,
    output logic                 priv_abort,
    output logic                 bif_illegal,
    output logic                 sw_load_abort,
    output logic                 cfg_rd_req,
    output logic [15:0]          cfg_rd_addr,
    output logic [15:0]          tmr_rdata,
    output logic                 tmr_rvalid
);

    // Register state
    logic [15:0]       fault_r;        // Sticky fault causes
    logic [15:0]       sw_r;           // Status word
    logic [15:0]       cfg_r;          // Configuration word
    logic [15:0]       pend_r;         // Pending interrupts
    logic [15:0]       mask_r;         // Interrupt mask
    logic [15:0]       irq_prev_r;     // Previous external request levels
    logic              major_r;        // Severity outputs
    logic              unrec_r;
    logic              unclass_r;
    logic              int_req_r;      // Service request to core
    logic [3:0]        int_level_r;    // Level of that request
    logic [15:0]       saved_mask_r;   // Mask saved on entry
    logic [15:0]       saved_ic_r;     // Counter saved on entry
    logic              priv_abort_r;
    logic              bif_ill_r;
    logic              sw_abort_r;
    logic [15:0]       cfg_addr_r;
    logic [15:0]       tmr_rdata_r;
    logic              tmr_rvalid_r;
    ccs_cfg_state_type cfg_state_r;
    ccs_cfg_state_type cfg_state_nxt;

    // Next values
    logic [15:0] fault_nxt;
    logic [15:0] sw_nxt;
    logic [15:0] pend_nxt;
    logic [15:0] mask_nxt;

    // Per-timer state, index 0 fast, index 1 slow
    logic [15:0] tmr_cnt_r [2];
    logic [11:0] tmr_pre_r [2];
    logic        tmr_run_r [2];
    logic [1:0]  tmr_wrap;         // Rollover pulses

    // Decoded conditions
    wire logic       mmu_present   = cfg_r[CFG_MMU];
    wire logic [3:0] ps_field      = sw_r[SW_PS_LSB +: 4];
    wire logic [3:0] as_wr_field   = sw_wdata[SW_AS_LSB +: 4];
    wire logic [3:0] as_int_field  = int_sw_data[SW_AS_LSB +: 4];
    wire logic       priv_bad      = priv_exec & (ps_field != 4'h0);
    wire logic       bif_bad       = bif_exec & ~cfg_r[CFG_COPROC];
    wire logic       as_wr_bad     = sw_we & ~mmu_present & (as_wr_field != 4'h0);
    wire logic       as_int_bad    = int_sw_load & ~mmu_present & (as_int_field != 4'h0);

    wire logic [15:0] fault_set = {fault_evt.sys1, 1'b0, fault_evt.builtin_test_fault, 1'b0,
                                   as_wr_bad | as_int_bad, priv_bad,
                                   fault_evt.ill_instr | bif_bad, fault_evt.ill_mem,
                                   fault_evt.sys0, 1'b0, fault_evt.ill_io, 2'b00,
                                   fault_evt.parity, fault_evt.ext_prot, fault_evt.cpu_prot};

    wire logic [15:0] ext_level = PI_LVL_ONLY | (cfg_r[CFG_LEVEL] ? PI_EXT_MASK : RST_WORD);
    wire logic [15:0] ext_set   = PI_EXT_MASK & ((ext_irq & ext_level) | (ext_irq & ~irq_prev_r & ~ext_level));

    // Internal interrupt sources
    logic [15:0] int_set;
    always_comb begin
        int_set = RST_WORD;
        int_set[PI_MACH_ERR]  = |fault_set;
        int_set[PI_FP_OVF]    = core_evt.fp_ovf;
        int_set[PI_FX_OVF]    = core_evt.fx_ovf;
        int_set[PI_EXEC_CALL] = core_evt.exec_call;
        int_set[PI_FP_UNF]    = core_evt.fp_unf;
        int_set[PI_FAST_TMR]  = tmr_wrap[0];
        int_set[PI_SLOW_TMR]  = tmr_wrap[1];
    end

    wire logic [15:0] ack_clr = int_ack ? (16'h0001 << int_ack_level) : RST_WORD;

    // Fault register: set wins over clear, spares stay zero
    assign fault_nxt = (fault_clr ? RST_WORD : fault_r) | fault_set;

    assign pend_nxt  = (pend_r & ~ack_clr) | ext_set | int_set;

    // Mask register load
    assign mask_nxt  = mask_we ? mask_wdata : mask_r;

    wire logic [15:0] mask_eff = mask_r | PI_NO_MASK;
    wire logic [15:0] enabled  = pend_r & mask_eff & (glob_disable ? PI_NO_DISABLE : 16'hFFFF);

    logic [3:0] sel_level;
    always_comb begin
        sel_level = 4'hF;
        for (int i = 15; i >= 0; i--) begin
            if (enabled[i]) begin
                sel_level = 4'(i);
            end
        end
    end

    // Status word next value
    always_comb begin
        sw_nxt = sw_r;
        if (int_sw_load) begin
            if (!as_int_bad) begin
                sw_nxt = int_sw_data & SW_WRITE_MASK;
            end
        end else if (sw_we) begin
            sw_nxt = sw_wdata & SW_WRITE_MASK;
            if (as_wr_bad) begin
                sw_nxt[SW_AS_LSB +: 4] = sw_r[SW_AS_LSB +: 4];
            end
        end
        if (flags_we) begin
            sw_nxt[SW_FLAG_LSB +: 4] = flags_in;
        end
        sw_nxt = sw_nxt & SW_WRITE_MASK;
    end

    // Configuration load sequencer next state
    always_comb begin
        cfg_state_nxt = cfg_state_r;
        unique case (cfg_state_r)
            CFG_IDLE: begin
                if (breakpoint) begin
                    cfg_state_nxt = CFG_WAIT;
                end
            end
            CFG_WAIT: begin
                if (cfg_rd_valid) begin
                    cfg_state_nxt = CFG_IDLE;
                end
            end
            default: cfg_state_nxt = CFG_WAIT;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg_state_r <= CFG_WAIT;
            cfg_r       <= RST_WORD;
            cfg_addr_r  <= CFG_IO_ADDR;
        end else begin
            cfg_state_r <= cfg_state_nxt;
            cfg_addr_r  <= CFG_IO_ADDR;
            if ((cfg_state_r == CFG_WAIT) && cfg_rd_valid) begin
                cfg_r <= cfg_rd_data & CFG_USED_MASK;
            end
        end
    end

    // Core registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fault_r    <= RST_WORD;
            sw_r       <= RST_WORD;
            pend_r     <= RST_WORD;
            mask_r     <= RST_WORD;
            irq_prev_r <= RST_WORD;
        end else begin
            fault_r    <= fault_nxt;
            sw_r       <= sw_nxt;
            pend_r     <= pend_nxt;
            mask_r     <= mask_nxt;
            irq_prev_r <= ext_irq;
        end
    end

    // Severity and abort pulses
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            major_r      <= 1'b0;
            unrec_r      <= 1'b0;
            unclass_r    <= 1'b0;
            priv_abort_r <= 1'b0;
            bif_ill_r    <= 1'b0;
            sw_abort_r   <= 1'b0;
        end else begin
            major_r      <= |(fault_nxt & FT_MAJOR_MASK);
            unrec_r      <= |(fault_nxt & FT_UNREC_MASK);
            unclass_r    <= |(fault_nxt & FT_UNCLASS_MASK);
            priv_abort_r <= priv_bad;
            bif_ill_r    <= bif_bad;
            sw_abort_r   <= as_int_bad;
        end
    end

    // Interrupt request and context save
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            int_req_r    <= 1'b0;
            int_level_r  <= 4'h0;
            saved_mask_r <= RST_WORD;
            saved_ic_r   <= RST_WORD;
        end else begin
            int_req_r    <= |(enabled & ~ack_clr);
            int_level_r  <= sel_level;
            if (int_ack) begin
                saved_mask_r <= mask_r;
                saved_ic_r   <= instruction_counter;
            end
        end
    end

    genvar t;
    generate
        for (t = 0; t < 2; t++) begin : g_tmr
            localparam logic [11:0] DIV = (t == 0) ? 12'(FAST_DIV) : 12'(SLOW_DIV);
            wire logic tick = (tmr_pre_r[t] == DIV - 12'h001);
            wire logic adv  = tmr_run_r[t] & ~console_mode & ~tmr_cmd.load_start[t] & ~tmr_cmd.halt[t];
            assign tmr_wrap[t] = adv & tick & (tmr_cnt_r[t] == 16'hFFFF);

            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    tmr_cnt_r[t] <= RST_WORD;
                    tmr_pre_r[t] <= 12'h000;
                    tmr_run_r[t] <= 1'b0;
                end else if (tmr_cmd.load_start[t]) begin
                    tmr_cnt_r[t] <= tmr_cmd.wdata;
                    tmr_pre_r[t] <= 12'h000;
                    tmr_run_r[t] <= 1'b1;
                end else if (tmr_cmd.halt[t]) begin
                    tmr_run_r[t] <= 1'b0;
                end else if (adv) begin
                    tmr_pre_r[t] <= tick ? 12'h000 : tmr_pre_r[t] + 12'h001;
                    if (tick) begin
                        tmr_cnt_r[t] <= tmr_cnt_r[t] + 16'h0001;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tmr_rdata_r  <= RST_WORD;
            tmr_rvalid_r <= 1'b0;
        end else begin
            tmr_rvalid_r <= |tmr_cmd.read;
            if (tmr_cmd.read[0]) begin
                tmr_rdata_r <= tmr_cnt_r[0];
            end else if (tmr_cmd.read[1]) begin
                tmr_rdata_r <= tmr_cnt_r[1];
            end
        end
    end

    // Outputs straight from flip-flops, except cfg_rd_req decoded from the sequencer state
    assign fault_cause          = fault_r;
    assign fault_major          = major_r;
    assign fault_unrec          = unrec_r;
    assign fault_unclass        = unclass_r;
    assign status_word          = sw_r;
    assign system_configuration = cfg_r;
    assign interrupt_pending    = pend_r;
    assign interrupt_mask       = mask_r;
    assign int_req              = int_req_r;
    assign int_level            = int_level_r;
    assign saved_mask           = saved_mask_r;
    assign saved_ic             = saved_ic_r;
    assign priv_abort           = priv_abort_r;
    assign bif_illegal          = bif_ill_r;
    assign sw_load_abort        = sw_abort_r;
    assign cfg_rd_req           = (cfg_state_r == CFG_WAIT);
    assign cfg_rd_addr          = cfg_addr_r;
    assign tmr_rdata            = tmr_rdata_r;
    assign tmr_rvalid           = tmr_rvalid_r;

endmodule

// [verification/ccs_regs_sva.sv]
// Checker for the control and status register block, bound onto its ports.
// Assumes one clock domain with the asynchronous active-low reset.
module ccs_chk
    import ccs_pkg::*;
(
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        fault_clr,
    input wire logic        int_ack,
    input wire logic        priv_exec,
    input wire logic        bif_exec,
    input wire logic        cfg_rd_valid,
    input wire logic [15:0] cfg_rd_data,
    input wire logic [15:0] fault_cause,
    input wire logic        fault_major,
    input wire logic [15:0] status_word,
    input wire logic [15:0] system_configuration,
    input wire logic [15:0] interrupt_pending,
    input wire logic        int_req,
    input wire logic [3:0]  int_level,
    input wire logic        priv_abort,
    input wire logic        bif_illegal,
    input wire logic        cfg_rd_req,
    input wire logic [15:0] cfg_rd_addr
);
    // All checks share the core clock and its reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    chk_spare_fault: assert property ((fault_cause & 16'h5058) == 16'h0000)
        else $error("spare fault bit set");
    chk_sw_reserved: assert property (status_word[7:4] == 4'h0)
        else $error("reserved status bits set");
    chk_cfg_unused: assert property (system_configuration[15:5] == 11'h000)
        else $error("unused config bits set");
    chk_cfg_addr: assert property (cfg_rd_req |-> cfg_rd_addr == 16'h8410)
        else $error("config read at wrong address");
    chk_cfg_load: assert property (cfg_rd_req && cfg_rd_valid |=>
        !cfg_rd_req && system_configuration == ($past(cfg_rd_data) & 16'h001F))
        else $error("config word not loaded");
    chk_priv_abort: assert property (priv_exec && status_word[11:8] != 4'h0 |=>
        priv_abort && fault_cause[10] && fault_major)
        else $error("privileged op not aborted");
    chk_bif_illegal: assert property (bif_exec && !system_configuration[3] |=>
        bif_illegal && fault_cause[9])
        else $error("builtin op not refused");
    chk_fault_sticky: assert property (!fault_clr |=>
        (fault_cause & $past(fault_cause)) == $past(fault_cause))
        else $error("fault bit lost");
    chk_power_down: assert property (interrupt_pending[0] && !int_ack |=> int_req && int_level == 4'h0)
        else $error("power down not served first");
endmodule

// [verification/ccs_cfg_model.sv]
// Model of the external hardware answering the configuration read.
// Assumes the bench sets the word and the answer delay.
module ccs_cfg_model
    import ccs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        cfg_rd_req,
    input  wire logic [15:0] cfg_rd_addr,
    input  wire logic [15:0] cfg_word,
    input  wire logic [7:0]  cfg_delay,
    output logic             cfg_rd_valid,
    output logic [15:0]      cfg_rd_data
);
    logic [7:0] wait_r; // Cycles spent on this request

    // Answer one read after the delay; released data toggles
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wait_r       <= 8'h00;
            cfg_rd_valid <= 1'b0;
            cfg_rd_data  <= 16'hA5A5;
        end else if (cfg_rd_valid || !cfg_rd_req || cfg_rd_addr != CFG_IO_ADDR) begin
            wait_r       <= 8'h00;
            cfg_rd_valid <= 1'b0;
            cfg_rd_data  <= ~cfg_rd_data;
        end else if (wait_r == cfg_delay) begin
            cfg_rd_valid <= 1'b1;
            cfg_rd_data  <= cfg_word;
        end else begin
            wait_r      <= wait_r + 8'h01;
            cfg_rd_data <= ~cfg_rd_data;
        end
    end
endmodule

// [verification/testbench.sv]
// Self-checking bench for the control and status register block.
// Assumes the package, design, checker and config model are compiled first.
module testbench
    import ccs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic            clk, resetn, fault_clr, flags_we, sw_we, int_sw_load, priv_exec, bif_exec;
    logic            breakpoint, console_mode, glob_disable, mask_we, int_ack, cfg_rd_valid;
    logic            fault_major, fault_unrec, fault_unclass, int_req, priv_abort, bif_illegal;
    logic            sw_load_abort, cfg_rd_req, tmr_rvalid;
    logic [3:0]      flags_in, int_ack_level, int_level;
    logic [7:0]      cfg_delay;
    logic [15:0]     sw_wdata, int_sw_data, ext_irq, mask_wdata, instruction_counter, cfg_rd_data;
    logic [15:0]     fault_cause, status_word, system_configuration, interrupt_pending, interrupt_mask;
    logic [15:0]     saved_mask, saved_ic, cfg_rd_addr, tmr_rdata, cfg_word;
    ccs_fault_type   fault_evt;
    ccs_event_type   core_evt;
    ccs_tmr_cmd_type tmr_cmd;
    int              failures, cmp_count;

    ccs_regs DUT (.*);
    ccs_cfg_model partner (.*);

    // Free-running 20 MHz clock
    always #25 clk = ~clk;

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t ns: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic set_mask(input logic [15:0] m);
        mask_wdata = m;
        pulse(mask_we);
    endtask
    // Accept the level on offer and let pending settle
    task automatic ack;
        int_ack_level = int_level;
        pulse(int_ack);
        cyc(1);
    endtask
    // Let the request settle each cycle, then accept whatever is offered
    task automatic drain;
        repeat (20) begin
            cyc(1);
            if (int_req === 1'b1) ack;
        end
    endtask
    task automatic reload(input logic [15:0] w);
        cfg_word = w;
        pulse(breakpoint);
        cyc(10);
    endtask
    task automatic rd(input int i, input logic [15:0] exp);
        tmr_cmd.read[i] = 1'b1;
        cyc(1);
        tmr_cmd.read = 2'b00;
        chk(16'(tmr_rvalid), 16'h0001, "read valid");
        chk(tmr_rdata, exp, "timer count");
    endtask

    // Reset answer with no options fitted
    task automatic t_reset;
        chk(16'(cfg_rd_req), 16'h0001, "config request");
        cyc(8);
        chk({cfg_rd_addr[15:1], cfg_rd_req}, 16'h8410, "request answered");
        chk(system_configuration, 16'h0000, "config word");
        $display("reset test done");
    endtask
    // Status writes and faults without MMU or coprocessor
    task automatic t_status;
        sw_wdata = 16'hF5A3;
        pulse(sw_we);
        chk(status_word, 16'h0503, "status no mmu");
        flags_in = 4'hA;
        pulse(flags_we);
        chk(status_word, 16'h050A, "flags");
        pulse(priv_exec);
        chk(16'(priv_abort), 16'h0001, "priv abort");
        pulse(bif_exec);
        chk(16'(bif_illegal), 16'h0001, "bif illegal");
        int_sw_data = 16'h1000;
        pulse(int_sw_load);
        chk(16'(sw_load_abort), 16'h0001, "entry abort");
        chk(status_word, 16'h050A, "status kept");
        chk(fault_cause, 16'h0E00, "faults 9 10 11");
        pulse(fault_clr);
        fault_evt = '1;
        cyc(1);
        fault_evt = '0;
        chk(fault_cause, 16'hA3A7, "fault bits");
        chk(16'({fault_major, fault_unrec, fault_unclass}), 16'h0007, "severity");
        $display("status test done");
    endtask
    // Reload on breakpoint with MMU and coprocessor present
    task automatic t_config;
        pulse(fault_clr);
        cfg_delay = 8'h05;
        reload(16'hFFEF);
        chk(system_configuration, 16'h000F, "reloaded config");
        sw_wdata = 16'h3000;
        pulse(sw_we);
        int_sw_data = 16'h20F1;
        pulse(int_sw_load);
        chk(status_word, 16'h2001, "entry status");
        priv_exec = 1'b1;
        pulse(bif_exec);
        priv_exec = 1'b0;
        chk(16'({priv_abort, bif_illegal}), 16'h0000, "legal ops");
        chk(fault_cause, 16'h0000, "no new fault");
        $display("config test done");
    endtask
    // Priority, masking, edge and level capture
    task automatic t_int;
        set_mask(16'h7FFF);
        chk(interrupt_mask, 16'h7FFF, "mask loaded");
        drain;
        ext_irq = 16'h8500;
        cyc(2);
        chk(16'({int_req, int_level}), 16'h0018, "highest first");
        instruction_counter = 16'h1234;
        ack;
        chk(saved_ic ^ saved_mask, 16'h6DCB, "saved words");
        chk(interrupt_pending & 16'h8500, 16'h8400, "edge once");
        drain;
        chk(16'(int_req), 16'h0000, "masked ignored");
        ext_irq = 16'h0000;
        set_mask(16'h0000);
        ext_irq = 16'h0001;
        cyc(2);
        chk(16'({int_req, int_level}), 16'h0010, "power down");
        drain;
        glob_disable = 1'b1;
        set_mask(16'hFFFF);
        core_evt.exec_call = 1'b1;
        cyc(1);
        core_evt.exec_call = 1'b0;
        cyc(1);
        chk(16'({int_req, int_level}), 16'h0015, "exec call");
        drain;
        chk(16'(int_req), 16'h0000, "disabled");
        glob_disable = 1'b0;
        drain;
        ext_irq = 16'h0000;
        reload(16'h001F);
        ext_irq = 16'h0100;
        cyc(2);
        ack;
        chk(interrupt_pending & 16'h0100, 16'h0100, "level relatch");
        ext_irq = 16'h0000;
        drain;
        $display("interrupt test done");
    endtask
    // Load and rollover of both timers, freeze of the fast timer, halt of the slow timer
    task automatic t_timer;
        tmr_cmd.wdata = 16'hFFFE;
        tmr_cmd.load_start = 2'b01;
        cyc(1);
        tmr_cmd.load_start = 2'b00;
        cyc(99);
        console_mode = 1'b1;
        cyc(500);
        rd(0, 16'hFFFE);
        console_mode = 1'b0;
        cyc(320);
        rd(0, 16'h0000);
        tmr_cmd.wdata = 16'hFFFF;
        tmr_cmd.load_start = 2'b10;
        cyc(1);
        tmr_cmd.load_start = 2'b00;
        cyc(2005);
        chk(interrupt_pending & 16'h0280, 16'h0280, "rollovers");
        tmr_cmd.halt = 2'b10;
        cyc(2100);
        rd(1, 16'h0000);
        $display("timer test done");
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Reset held four cycles, then the scenarios in turn
    initial begin
        {clk, resetn, fault_clr, flags_we, sw_we, int_sw_load, priv_exec, bif_exec, breakpoint,
         console_mode, glob_disable, mask_we, int_ack, fault_evt, core_evt, flags_in, int_ack_level,
         sw_wdata, int_sw_data, ext_irq, mask_wdata, instruction_counter, tmr_cmd, cfg_word} = '0;
        cfg_delay = 8'h03;
        failures = 0;
        cmp_count = 0;
        cyc(4);
        resetn = 1'b1;
        t_reset;
        t_status;
        t_config;
        t_int;
        t_timer;
        results;
    end

    // Cut a hang short well after the tests should end
    initial begin
        #1000000;
        failures++;
        $display("wrong value at %0t ns: watchdog expired", $time);
        results;
    end
endmodule

bind ccs_regs ccs_chk chk_i (.*);
